/* verilog/pmr_pkg.sv */
// Package for the power-management and interrupt-message register block
package pmr_pkg;
    localparam logic [7:0] PMR_OFF_PM = 8'h44;
    localparam logic [7:0] PMR_OFF_MSI_CTRL = 8'h4c;
    localparam logic [7:0] PMR_OFF_MSI_ADDR = 8'h50;
    localparam logic [7:0] PMR_OFF_MSI_UADDR = 8'h54;
    localparam logic [7:0] PMR_OFF_MSI_DATA = 8'h58;
    localparam logic [7:0] PMR_OFF_IRQ_STAT = 8'h80;
    localparam logic [7:0] PMR_OFF_IRQ_MASK = 8'h84;
    localparam logic [7:0] PMR_OFF_LOAD = 8'h88;
    localparam logic [7:0] PMR_OFF_MSG_STAT = 8'h8c;
    localparam logic [1:0] PMR_STATE_D0 = 2'h0;
    localparam logic [1:0] PMR_STATE_D3 = 2'h3;
    localparam logic PMR_SKIP_RST_INIT = 1'b1;
    localparam logic [7:0] PMR_DATA_BYTE_INIT = 8'h00;
    localparam logic [7:0] PMR_CAP_ID = 8'h05;
    localparam logic [7:0] PMR_NEXT_PTR = 8'h64;
    localparam int PMR_PS_LSB = 0;
    localparam int PMR_SKIP_BIT = 3;
    localparam int PMR_PME_EN_BIT = 8;
    localparam int PMR_DSEL_LSB = 9;
    localparam int PMR_DATA_LSB = 24;
    localparam int PMR_MSI_EN_BIT = 16;
    localparam int PMR_MME_LSB = 20;
    localparam int PMR_A64_BIT = 23;
    localparam int PMR_RST_PULSE_NS = 100;
    localparam int PMR_CLK_NS = 20;
    localparam int PMR_RST_PULSE_CYC = (PMR_RST_PULSE_NS + PMR_CLK_NS - 1) / PMR_CLK_NS;
    localparam logic [1:0] PMR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PMR_RESP_SLVERR = 2'h2;
    // Interrupt status bits
    localparam int PMR_EV_HOTRST = 0;
    localparam int PMR_EV_INTRST = 1;
    localparam int PMR_EV_MSGSENT = 2;
    localparam int PMR_NEV = 3;

    typedef struct packed {
        logic valid;
        logic [63:0] addr;
        logic [15:0] data;
    } pmr_msg_type;
endpackage

/* verilog/pmr_regs.sv */
// Power-management and interrupt-message register block with AXI4-Lite slave
`timescale 1ns/1ps
// Behaviour
// R1: Two-bit power state, reset D0
// R2: Write D0 after D3 gives hot reset
// R3: Skip flag set: no internal reset
// R4: Skip flag clear: internal reset D3-to-D0
// R5: Sticky PME enable permits event message
// R6: PME status always reads zero
// R7: Bus power bits hardwired zero
// R8: Data byte read-only, reloadable default
// R9: Capability identifier reads 05h
// R10: Next pointer reads 64h
// R11: MSI enable selects message or pin
// R12: 64-bit capable flag reads one
// R13: Message address bits 31:2 writable
// R14: Upper address used for 64-bit messages
// R15: Requests sent as message writes
module pmr_regs
    import pmr_pkg::*;
#(
    parameter int RST_CYC = PMR_RST_PULSE_CYC
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sticky_resetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic service_req,
    output logic legacy_int_out,
    output pmr_pkg::pmr_msg_type msg_out,
    input wire logic msg_ready,
    output logic pme_permit,
    output logic hot_reset_out,
    output logic internal_reset_out,
    output logic downstream_reset_out,
    output logic irq
);
    import pmr_pkg::*;

    if (RST_CYC < 1 || RST_CYC > 255)
    begin : gen_rst_cyc_check
        $error("RST_CYC out of range");
    end

    logic [1:0] pstate_q;
    logic pme_en_q;
    logic [3:0] dsel_q;
    logic skip_rst_q;
    logic [7:0] data_byte_q;
    logic msi_en_q;
    logic [2:0] mme_q;
    logic [29:0] maddr_q;
    logic [31:0] uaddr_q;
    logic [15:0] mdata_q;
    logic [PMR_NEV-1:0] stat_q;
    logic [PMR_NEV-1:0] mask_q;
    logic [7:0] hot_cnt_q;
    logic [7:0] int_cnt_q;
    logic [31:0] awaddr_q;
    logic aw_full_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_full_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    pmr_msg_type msg_q;

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        return a == PMR_OFF_PM || a == PMR_OFF_MSI_CTRL || a == PMR_OFF_MSI_ADDR
            || a == PMR_OFF_MSI_UADDR || a == PMR_OFF_MSI_DATA || a == PMR_OFF_IRQ_STAT
            || a == PMR_OFF_IRQ_MASK || a == PMR_OFF_LOAD || a == PMR_OFF_MSG_STAT;
    endfunction

    // Write channel acceptance
    wire aw_take = s_axi_awvalid && !aw_full_q;
    wire w_take = s_axi_wvalid && !w_full_q;
    wire do_write = aw_full_q && w_full_q && !bvalid_q;
    wire [7:0] wa = (awaddr_q[31:8] == 24'h0) ? awaddr_q[7:0] : 8'hff;
    wire wr_ok = known_addr(wa) && awaddr_q[1:0] == 2'h0;
    wire wr_pm = do_write && wr_ok && wa == PMR_OFF_PM;
    wire wr_ctl = do_write && wr_ok && wa == PMR_OFF_MSI_CTRL;
    wire wr_addr = do_write && wr_ok && wa == PMR_OFF_MSI_ADDR;
    wire wr_uaddr = do_write && wr_ok && wa == PMR_OFF_MSI_UADDR;
    wire wr_data = do_write && wr_ok && wa == PMR_OFF_MSI_DATA;
    wire wr_stat = do_write && wr_ok && wa == PMR_OFF_IRQ_STAT;
    wire wr_mask = do_write && wr_ok && wa == PMR_OFF_IRQ_MASK;
    wire wr_load = do_write && wr_ok && wa == PMR_OFF_LOAD;

    // R6 R7: hardwired zero bits
    wire [31:0] pm_word = {data_byte_q, 8'h00, 1'b0, 2'h0, dsel_q, pme_en_q,
        4'h0, skip_rst_q, 1'b0, pstate_q};
    // R9 R10 R12: fixed capability header
    wire [31:0] ctl_word = {8'h00, 1'b1, mme_q, 3'h0, msi_en_q, PMR_NEXT_PTR, PMR_CAP_ID};
    wire [31:0] pm_new = lane_merge(pm_word, wdata_q, wstrb_q);
    wire [31:0] ctl_new = lane_merge(ctl_word, wdata_q, wstrb_q);
    wire [31:0] addr_new = lane_merge({maddr_q, 2'h0}, wdata_q, wstrb_q);
    wire [31:0] load_new = lane_merge({23'h0, skip_rst_q, data_byte_q}, wdata_q, wstrb_q);
    wire [31:0] data_new = lane_merge({16'h0, mdata_q}, wdata_q, wstrb_q);
    wire [1:0] ps_wr = pm_new[PMR_PS_LSB +: 2];
    wire leave_d3 = wr_pm && pstate_q == PMR_STATE_D3 && ps_wr == PMR_STATE_D0;
    wire [PMR_NEV-1:0] ev;
    wire a64 = uaddr_q != 32'h0;
    wire msg_go = msi_en_q && service_req && !msg_q.valid;
    wire [7:0] ra = (s_axi_araddr[31:8] == 24'h0) ? s_axi_araddr[7:0] : 8'hff;
    wire rd_ok = known_addr(ra) && s_axi_araddr[1:0] == 2'h0;
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0;
        unique case (ra)
            PMR_OFF_PM: rd_mux = pm_word;
            PMR_OFF_MSI_CTRL: rd_mux = ctl_word;
            PMR_OFF_MSI_ADDR: rd_mux = {maddr_q, 2'h0};
            PMR_OFF_MSI_UADDR: rd_mux = uaddr_q;
            PMR_OFF_MSI_DATA: rd_mux = {16'h0, mdata_q};
            PMR_OFF_IRQ_STAT: rd_mux = {29'h0, stat_q};
            PMR_OFF_IRQ_MASK: rd_mux = {29'h0, mask_q};
            PMR_OFF_LOAD: rd_mux = {23'h0, skip_rst_q, data_byte_q};
            PMR_OFF_MSG_STAT: rd_mux = {31'h0, msg_q.valid};
            default: rd_mux = 32'h0;
        endcase
    end

    assign ev[PMR_EV_HOTRST] = leave_d3;
    assign ev[PMR_EV_INTRST] = leave_d3 && !skip_rst_q;
    assign ev[PMR_EV_MSGSENT] = msg_q.valid && msg_ready;

    // AXI4-Lite handshakes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= PMR_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? PMR_RESP_OKAY : PMR_RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= PMR_RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_ok ? rd_mux : 32'h0;
            rresp_q <= rd_ok ? PMR_RESP_OKAY : PMR_RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // R1: power state field
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pstate_q <= PMR_STATE_D0;
            dsel_q <= 4'h0;
        end
        else if (wr_pm)
        begin
            pstate_q <= ps_wr;
            dsel_q <= pm_new[PMR_DSEL_LSB +: 4];
        end
    end

    // R5: sticky enable survives port reset
    always_ff @(posedge aclk)
    begin
        if (!sticky_resetn)
            pme_en_q <= 1'b0;
        else if (wr_pm)
            pme_en_q <= pm_new[PMR_PME_EN_BIT];
    end

    // R3: reloadable defaults, R8: data byte
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            skip_rst_q <= PMR_SKIP_RST_INIT;
            data_byte_q <= PMR_DATA_BYTE_INIT;
        end
        else if (wr_load)
        begin
            skip_rst_q <= load_new[8];
            data_byte_q <= load_new[7:0];
        end
    end

    // R11: enable, R13: address, R14: upper half
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            msi_en_q <= 1'b0;
            mme_q <= 3'h0;
            maddr_q <= 30'h0;
            uaddr_q <= 32'h0;
            mdata_q <= 16'h0;
        end
        else
        begin
            if (wr_ctl)
            begin
                msi_en_q <= ctl_new[PMR_MSI_EN_BIT];
                mme_q <= ctl_new[PMR_MME_LSB +: 3];
            end
            if (wr_addr)
                maddr_q <= addr_new[31:2];
            if (wr_uaddr)
                uaddr_q <= lane_merge(uaddr_q, wdata_q, wstrb_q);
            if (wr_data)
                mdata_q <= data_new[15:0];
        end
    end

    // R2: hot reset pulse, R4: internal reset pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hot_cnt_q <= 8'h0;
            int_cnt_q <= 8'h0;
        end
        else
        begin
            hot_cnt_q <= leave_d3 ? 8'(RST_CYC) : (hot_cnt_q != 8'h0 ? hot_cnt_q - 8'h1 : 8'h0);
            int_cnt_q <= ev[PMR_EV_INTRST] ? 8'(RST_CYC)
                : (int_cnt_q != 8'h0 ? int_cnt_q - 8'h1 : 8'h0);
        end
    end

    // R15: message write of data to programmed address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            msg_q <= '0;
        else if (msg_go)
        begin
            msg_q.valid <= 1'b1;
            msg_q.addr <= {a64 ? uaddr_q : 32'h0, maddr_q, 2'h0};
            msg_q.data <= mdata_q;
        end
        else if (msg_q.valid && msg_ready)
            msg_q.valid <= 1'b0;
    end

    // Sticky status, set beats write-one clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stat_q <= '0;
            mask_q <= '0;
        end
        else
        begin
            stat_q <= (stat_q & ~(wr_stat ? wdata_q[PMR_NEV-1:0] : '0)) | ev;
            if (wr_mask)
                mask_q <= wdata_q[PMR_NEV-1:0];
        end
    end

    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    // R11: pin only while messages are off
    assign legacy_int_out = service_req && !msi_en_q;
    assign msg_out = msg_q;
    assign pme_permit = pme_en_q;
    assign hot_reset_out = hot_cnt_q != 8'h0;
    // R3: skip flag suppresses internal reset
    assign internal_reset_out = int_cnt_q != 8'h0;
    // R2: downstream reset tied low, never asserted here
    assign downstream_reset_out = 1'b0;
    assign irq = |(stat_q & mask_q);

    // R2: D3 to D0 write starts hot reset
    AST_HOTRST: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        leave_d3 |=> hot_reset_out && !downstream_reset_out)
        else $error("hot reset missing");
    AST_SKIP: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        (leave_d3 && skip_rst_q && !internal_reset_out) |=> !internal_reset_out)
        else $error("internal reset despite skip");
    AST_INTRST: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        (leave_d3 && !skip_rst_q) |=> internal_reset_out ##1 (internal_reset_out || RST_CYC == 1))
        else $error("internal reset missing");
    AST_PSTATE: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        wr_pm |=> pstate_q == $past(ps_wr))
        else $error("power state not stored");
    AST_PMERO: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        pm_word[15] == 1'b0 && pm_word[23:22] == 2'h0)
        else $error("hardwired bits nonzero");
    AST_CAPHDR: assert property (@(posedge aclk) disable iff (!aresetn) // R9
        ctl_word[15:0] == 16'h6405 && ctl_word[PMR_A64_BIT])
        else $error("capability header wrong");
    AST_LEGACY: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        msi_en_q |-> !legacy_int_out && (!msg_go || service_req))
        else $error("pin used with messages on");
    AST_MSG: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        msg_go |=> msg_q.valid && msg_q.addr[31:0] == {$past(maddr_q), 2'h0}
            && msg_q.data == $past(mdata_q))
        else $error("message write wrong");
    AST_NOMSG: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        (!msi_en_q && !msg_q.valid) |=> !msg_q.valid)
        else $error("message sent while disabled");
endmodule

/* verification/test_pmr_regs.sv */
// Self-checking bench for the power-management and interrupt-message registers
`timescale 1ns/1ps
module test_pmr_regs;
    import pmr_pkg::*;
    localparam int RST_N = 3;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic sticky_resetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic service_req = 1'b0, msg_ready = 1'b0;
    logic legacy_int_out, pme_permit, hot_reset_out, internal_reset_out;
    logic downstream_reset_out, irq;
    pmr_msg_type msg;
    int err_total = 0, tests_run = 0, hot_cnt = 0, int_cnt = 0, ds_cnt = 0;

    always #10 aclk = ~aclk;

    // Pulse lengths, counted where outputs are settled
    always @(negedge aclk)
    begin
        if (hot_reset_out === 1'b1) hot_cnt++;
        if (internal_reset_out === 1'b1) int_cnt++;
        if (downstream_reset_out !== 1'b0) ds_cnt++;
    end

    pmr_regs #(.RST_CYC(RST_N)) DUT (.aclk(aclk), .aresetn(aresetn),
        .sticky_resetn(sticky_resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .service_req(service_req), .legacy_int_out(legacy_int_out), .msg_out(msg),
        .msg_ready(msg_ready), .pme_permit(pme_permit), .hot_reset_out(hot_reset_out),
        .internal_reset_out(internal_reset_out),
        .downstream_reset_out(downstream_reset_out), .irq(irq));

    task automatic end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        begin
            tests_run++;
            if (seen !== exp)
            begin
                err_total++;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task automatic stuck;
        begin
            err_total++;
            end_of_test;
        end
    endtask

    // Handshakes are sampled at the falling edge, where nothing moves until the next rise
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        bit aw_go, w_go, b_go;
        logic [1:0] resp;
        begin
            awaddr <= {24'h0, a};
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            n = 0;
            b_go = 1'b0;
            while (!b_go && n < 50)
            begin
                @(negedge aclk);
                aw_go = awvalid && awready;
                w_go = wvalid && wready;
                b_go = (bvalid === 1'b1);
                resp = bresp;
                @(posedge aclk);
                if (aw_go) awvalid <= 1'b0;
                if (w_go) wvalid <= 1'b0;
                n++;
            end
            bready <= 1'b0;
            @(posedge aclk);
            if (!b_go) stuck;
            check(resp, er);
        end
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        bit ar_go, r_go;
        logic [31:0] d;
        logic [1:0] resp;
        begin
            araddr <= {24'h0, a};
            arvalid <= 1'b1;
            rready <= 1'b1;
            n = 0;
            r_go = 1'b0;
            while (!r_go && n < 50)
            begin
                @(negedge aclk);
                ar_go = arvalid && arready;
                r_go = (rvalid === 1'b1);
                d = rdata;
                resp = rresp;
                @(posedge aclk);
                if (ar_go) arvalid <= 1'b0;
                n++;
            end
            rready <= 1'b0;
            @(posedge aclk);
            if (!r_go) stuck;
            check(d, ed);
            check(resp, er);
        end
    endtask

    // Power-state write, then counts of both reset pulses
    task automatic wake(input int exp_hot, input int exp_int);
        int h0;
        int i0;
        begin
            axi_write(8'h44, 32'h0000_0103, PMR_RESP_OKAY);
            h0 = hot_cnt;
            i0 = int_cnt;
            axi_write(8'h44, 32'h0000_0100, PMR_RESP_OKAY);
            repeat (20) @(posedge aclk);
            check(hot_cnt - h0, exp_hot);
            check(int_cnt - i0, exp_int);
        end
    endtask

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        sticky_resetn <= 1'b1;
        @(posedge aclk);
        axi_read(8'h44, 32'h0000_0008, PMR_RESP_OKAY);
        axi_read(8'h4c, 32'h0080_6405, PMR_RESP_OKAY);
        axi_read(8'h50, 32'h0, PMR_RESP_OKAY);
        axi_read(8'h54, 32'h0, PMR_RESP_OKAY);
        axi_write(8'h44, 32'hffff_ffff, PMR_RESP_OKAY);
        axi_read(8'h44, 32'h0000_1f0b, PMR_RESP_OKAY);
        @(negedge aclk);
        check(pme_permit, 1'b1);
        @(posedge aclk);
        wake(RST_N, 0);
        check(ds_cnt, 0);
        axi_read(8'h80, 32'h0000_0001, PMR_RESP_OKAY);
        // Status with mask closed, then open, then cleared
        axi_write(8'h84, 32'h0, PMR_RESP_OKAY);
        @(negedge aclk);
        check(irq, 1'b0);
        @(posedge aclk);
        axi_write(8'h84, 32'h7, PMR_RESP_OKAY);
        @(negedge aclk);
        check(irq, 1'b1);
        @(posedge aclk);
        axi_write(8'h80, 32'h7, PMR_RESP_OKAY);
        axi_read(8'h80, 32'h0, PMR_RESP_OKAY);
        check(irq, 1'b0);
        // Reloaded defaults: skip flag clear, new data byte
        axi_write(8'h88, 32'h0000_00a5, PMR_RESP_OKAY);
        axi_read(8'h44, 32'ha500_0100, PMR_RESP_OKAY);
        wake(RST_N, RST_N);
        axi_read(8'h80, 32'h0000_0003, PMR_RESP_OKAY);
        service_req <= 1'b1;
        @(negedge aclk);
        check(legacy_int_out, 1'b1);
        check(msg.valid, 1'b0);
        @(posedge aclk);
        service_req <= 1'b0;
        axi_write(8'h50, 32'hffff_ffff, PMR_RESP_OKAY);
        axi_read(8'h50, 32'hffff_fffc, PMR_RESP_OKAY);
        axi_write(8'h54, 32'h1234_5678, PMR_RESP_OKAY);
        axi_read(8'h54, 32'h1234_5678, PMR_RESP_OKAY);
        axi_write(8'h58, 32'h0000_beef, PMR_RESP_OKAY);
        axi_write(8'h4c, 32'hffff_ffff, PMR_RESP_OKAY);
        axi_read(8'h4c, 32'h00f1_6405, PMR_RESP_OKAY);
        service_req <= 1'b1;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        check(legacy_int_out, 1'b0);
        check(msg.valid, 1'b1);
        check(msg.addr, 64'h1234_5678_ffff_fffc);
        check(msg.data, 16'hbeef);
        @(posedge aclk);
        msg_ready <= 1'b1;
        service_req <= 1'b0;
        @(posedge aclk);
        msg_ready <= 1'b0;
        repeat (2) @(posedge aclk);
        axi_read(8'h80, 32'h0000_0007, PMR_RESP_OKAY);
        check(msg.valid, 1'b0);
        // Unmapped and unaligned places
        axi_write(8'h30, 32'hffff_ffff, PMR_RESP_SLVERR);
        axi_read(8'h30, 32'h0, PMR_RESP_SLVERR);
        axi_read(8'h45, 32'h0, PMR_RESP_SLVERR);
        // Port reset alone keeps the sticky enable
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(8'h44, 32'h0000_0108, PMR_RESP_OKAY);
        axi_read(8'h4c, 32'h0080_6405, PMR_RESP_OKAY);
        check(pme_permit, 1'b1);
        end_of_test;
    end
endmodule
